/* core/ldo_monitor_pkg.sv */
// Register map, field positions and types of the regulator monitor.
package ldo_monitor_pkg;
    localparam int AddrWidth = 4;
    localparam int DataWidth = 16;
    localparam int TrimWidth = 9;
    localparam logic [3:0] CtrlOffset = 4'h0;
    localparam logic [3:0] StatusOffset = 4'h2;
    localparam logic [3:0] CurTrimOffset = 4'h4;
    localparam logic [3:0] VolTrimOffset = 4'h6;
    localparam logic [3:0] OcFiltOffset = 4'h8;
    localparam logic [3:0] OvFiltOffset = 4'ha;
    localparam int CtrlOvDetBit = 0;
    localparam int CtrlOvIrqBit = 1;
    localparam int CtrlOcIrqBit = 2;
    localparam int StPumpBit = 15;
    localparam int StOcLiveBit = 3;
    localparam int StOvLiveBit = 2;
    localparam int StOcFlagBit = 1;
    localparam int StOvFlagBit = 0;
    localparam int FilterDivide = 16;
    localparam logic [15:0] ResetZero = 16'h0000;

    typedef struct packed {
        logic [AddrWidth-1:0] addr;
        logic [DataWidth-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic pumpOk;
        logic overCurrent;
        logic overVoltage;
    } detect_t;
endpackage

/* core/ldo_monitor_register_bank.sv */
// Control, status, trim and filter registers of the regulator monitor.
//
// Contract
// RULE1: Overcurrent enable gates overcurrent interrupt.
// RULE2: Overvoltage enable gates overvoltage interrupt.
// RULE3: Control bit 0 enables overvoltage detection.
// RULE4: Status bit 15 mirrors pump ok live.
// RULE5: Status bit 3 shows live overcurrent.
// RULE6: Status bit 2 shows live overvoltage.
// RULE7: Overcurrent flag sets; write one clears, resets filter.
// RULE8: Overcurrent filter samples at clock divided 16.
// RULE9: Overvoltage flag sets; write one clears, resets filter.
// RULE10: Reserved bits read zero, ignore writes; the control register keeps and reads back all 16 bits.
// RULE11: Trim registers hold nine bits together.
// RULE12: Overcurrent filter needs count agreeing samples.
// RULE13: Overvoltage filter with own count register.
// RULE14: One interrupt from gated flags.
// RULE15: Flags stay set until software clears.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ldo_monitor_register_bank
    import ldo_monitor_pkg::*;
#(
    parameter int CountWidth = DataWidth,
    parameter int DivideBy = FilterDivide
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire bus_req_t busReq,
    output logic [DataWidth-1:0] rdata,
    // Analog detectors
    input wire detect_t detect,
    output logic overvoltageDetectEnable,
    output logic [TrimWidth-1:0] currentTrimValue,
    output logic [TrimWidth-1:0] voltageTrimValue,
    // Interrupt
    output logic irq
);
    logic [DataWidth-1:0] ctrl_q;
    logic [TrimWidth-1:0] curTrim_q, volTrim_q;
    logic [CountWidth-1:0] ocCount_q, ovCount_q;
    logic ocFlag_q, ovFlag_q;
    localparam int DivWidth = $clog2(DivideBy);
    localparam logic [DivWidth-1:0] DivLast = DivWidth'(DivideBy - 1);
    logic [DivWidth-1:0] div_q;
    logic [DivWidth:0] tickGap_q;
    logic sampleTick;
    logic ocFilt, ovFilt, ocClear, ovClear;
    logic [DataWidth-1:0] statusWord;

    function automatic logic hit(input bus_req_t r, input logic [3:0] off);
        return r.wr && (r.addr == off);
    endfunction

    // RULE8: sample tick divider
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= '0;
        end else if (sampleTick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DivWidth'(1);
        end
    end
    assign sampleTick = (div_q == DivLast);

    // RULE8: clocks since the last tick, for the spacing check
    always_ff @(posedge clk) begin
        if (rst || sampleTick) begin
            tickGap_q <= '0;
        end else begin
            tickGap_q <= tickGap_q + (DivWidth + 1)'(1);
        end
    end

    assign ocClear = hit(busReq, StatusOffset) && busReq.wdata[StOcFlagBit];
    assign ovClear = hit(busReq, StatusOffset) && busReq.wdata[StOvFlagBit];

    // RULE1: control holds enable bits; RULE3: detect enable output
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= ResetZero;
        end else if (hit(busReq, CtrlOffset)) begin
            ctrl_q <= busReq.wdata;
        end
    end
    assign overvoltageDetectEnable = ctrl_q[CtrlOvDetBit];

    // RULE11: nine bit trims written whole
    always_ff @(posedge clk) begin
        if (rst) begin
            curTrim_q <= ResetZero[TrimWidth-1:0];
            volTrim_q <= ResetZero[TrimWidth-1:0];
        end else begin
            if (hit(busReq, CurTrimOffset)) curTrim_q <= busReq.wdata[TrimWidth-1:0];
            if (hit(busReq, VolTrimOffset)) volTrim_q <= busReq.wdata[TrimWidth-1:0];
        end
    end
    assign currentTrimValue = curTrim_q;
    assign voltageTrimValue = volTrim_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ocCount_q <= ResetZero[CountWidth-1:0];
            ovCount_q <= ResetZero[CountWidth-1:0];
        end else begin
            if (hit(busReq, OcFiltOffset)) ocCount_q <= busReq.wdata[CountWidth-1:0];
            if (hit(busReq, OvFiltOffset)) ovCount_q <= busReq.wdata[CountWidth-1:0];
        end
    end

    // RULE12: overcurrent filter; RULE13: overvoltage filter
    logic [CountWidth-1:0] agree_q [2];
    logic accepted_q [2];
    logic rawIn [2];
    logic clrIn [2];
    logic [CountWidth-1:0] need [2];
    assign rawIn[0] = detect.overCurrent;
    assign rawIn[1] = detect.overVoltage && ctrl_q[CtrlOvDetBit];
    assign clrIn[0] = ocClear;
    assign clrIn[1] = ovClear;
    assign need[0] = ocCount_q;
    assign need[1] = ovCount_q;
    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            always_ff @(posedge clk) begin
                if (rst || clrIn[i]) begin
                    agree_q[i] <= '0;
                    accepted_q[i] <= 1'b0;
                end else if (sampleTick) begin
                    if (rawIn[i] == accepted_q[i]) begin
                        agree_q[i] <= '0;
                    end else if (agree_q[i] + CountWidth'(1) >= need[i]) begin
                        agree_q[i] <= '0;
                        accepted_q[i] <= rawIn[i];
                    end else begin
                        agree_q[i] <= agree_q[i] + CountWidth'(1);
                    end
                end
            end
        end
    endgenerate
    assign ocFilt = (ocCount_q == '0) ? rawIn[0] : accepted_q[0];
    assign ovFilt = (ovCount_q == '0) ? rawIn[1] : accepted_q[1];

    // RULE7: RULE9: RULE15: sticky flags, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ocFlag_q <= 1'b0;
            ovFlag_q <= 1'b0;
        end else begin
            ocFlag_q <= ocFilt | (ocFlag_q & ~ocClear);
            ovFlag_q <= ovFilt | (ovFlag_q & ~ovClear);
        end
    end

    // RULE4: RULE5: RULE6: RULE10: status word
    always_comb begin
        statusWord = '0;
        statusWord[StPumpBit] = detect.pumpOk;
        statusWord[StOcLiveBit] = ocFilt;
        statusWord[StOvLiveBit] = ovFilt;
        statusWord[StOcFlagBit] = ocFlag_q;
        statusWord[StOvFlagBit] = ovFlag_q;
    end

    // RULE10: read mux, reserved bits zero except control, which reads back all 16 bits
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (busReq.rd) begin
            case (busReq.addr)
                CtrlOffset: rdata <= ctrl_q;
                StatusOffset: rdata <= statusWord;
                CurTrimOffset: rdata <= DataWidth'(curTrim_q);
                VolTrimOffset: rdata <= DataWidth'(volTrim_q);
                OcFiltOffset: rdata <= DataWidth'(ocCount_q);
                OvFiltOffset: rdata <= DataWidth'(ovCount_q);
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // RULE2: RULE14: gated interrupt
    assign irq = (ocFlag_q & ctrl_q[CtrlOcIrqBit]) | (ovFlag_q & ctrl_q[CtrlOvIrqBit]);

    property p_irq_gate;
        @(posedge clk) disable iff (rst)
        irq == ((ocFlag_q && ctrl_q[CtrlOcIrqBit]) || (ovFlag_q && ctrl_q[CtrlOvIrqBit]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch"); // RULE14

    property p_oc_sticky;
        @(posedge clk) disable iff (rst)
        (ocFlag_q && !ocClear) |=> ocFlag_q;
    endproperty
    a_oc_sticky: assert property (p_oc_sticky) else $error("oc flag lost"); // RULE15

    property p_ov_sticky;
        @(posedge clk) disable iff (rst)
        (ovFlag_q && !ovClear) |=> ovFlag_q;
    endproperty
    a_ov_sticky: assert property (p_ov_sticky) else $error("ov flag lost"); // RULE9

    property p_oc_set;
        @(posedge clk) disable iff (rst)
        ocFilt |=> ocFlag_q;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("oc flag not set"); // RULE7

    property p_pump_rd;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == StatusOffset) |=> rdata[StPumpBit] == $past(detect.pumpOk);
    endproperty
    a_pump_rd: assert property (p_pump_rd) else $error("pump bit wrong"); // RULE4

    property p_rsvd;
        @(posedge clk) disable iff (rst)
        $past(busReq.rd && busReq.addr == StatusOffset) |-> rdata[14:4] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved nonzero"); // RULE10

    property p_trim_rsvd;
        @(posedge clk) disable iff (rst)
        $past(busReq.rd && busReq.addr == CurTrimOffset) |-> rdata[15:9] == '0;
    endproperty
    a_trim_rsvd: assert property (p_trim_rsvd) else $error("trim reserved nonzero"); // RULE11

    property p_bypass;
        @(posedge clk) disable iff (rst)
        (ocCount_q == '0) |-> ocFilt == detect.overCurrent;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass broken"); // RULE12

    property p_ov_det;
        @(posedge clk) disable iff (rst)
        (!ctrl_q[CtrlOvDetBit] && ovCount_q == '0) |-> !ovFilt;
    endproperty
    a_ov_det: assert property (p_ov_det) else $error("ov seen while disabled"); // RULE3

    property p_tick;
        @(posedge clk) disable iff (rst)
        sampleTick |-> tickGap_q == {1'b0, DivLast};
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing wrong"); // RULE8

    property p_oc_clr_win;
        @(posedge clk) disable iff (rst)
        (ocClear && ocFilt) |=> ocFlag_q;
    endproperty
    a_oc_clr_win: assert property (p_oc_clr_win) else $error("oc set lost to clear"); // RULE7

    property p_oc_clr;
        @(posedge clk) disable iff (rst)
        (ocClear && !ocFilt) |=> !ocFlag_q;
    endproperty
    a_oc_clr: assert property (p_oc_clr) else $error("oc flag not cleared"); // RULE7

    property p_ov_set;
        @(posedge clk) disable iff (rst)
        ovFilt |=> ovFlag_q;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("ov flag not set"); // RULE9

    property p_ov_clr;
        @(posedge clk) disable iff (rst)
        (ovClear && !ovFilt) |=> !ovFlag_q;
    endproperty
    a_ov_clr: assert property (p_ov_clr) else $error("ov flag not cleared"); // RULE9

    property p_oc_filt_clr;
        @(posedge clk) disable iff (rst)
        ocClear |=> (agree_q[0] == '0) && !accepted_q[0];
    endproperty
    a_oc_filt_clr: assert property (p_oc_filt_clr) else $error("oc filter kept state"); // RULE7

    property p_ov_filt_clr;
        @(posedge clk) disable iff (rst)
        ovClear |=> (agree_q[1] == '0) && !accepted_q[1];
    endproperty
    a_ov_filt_clr: assert property (p_ov_filt_clr) else $error("ov filter kept state"); // RULE9

    property p_oc_live;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == StatusOffset) |=> rdata[StOcLiveBit] == $past(ocFilt);
    endproperty
    a_oc_live: assert property (p_oc_live) else $error("oc live bit wrong"); // RULE5

    property p_ov_live;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == StatusOffset) |=> rdata[StOvLiveBit] == $past(ovFilt);
    endproperty
    a_ov_live: assert property (p_ov_live) else $error("ov live bit wrong"); // RULE6

    property p_oc_irq_off;
        @(posedge clk) disable iff (rst)
        (!ctrl_q[CtrlOcIrqBit] && !ovFlag_q) |-> !irq;
    endproperty
    a_oc_irq_off: assert property (p_oc_irq_off) else $error("oc irq while disabled"); // RULE1

    property p_ov_irq_off;
        @(posedge clk) disable iff (rst)
        (!ctrl_q[CtrlOvIrqBit] && !ocFlag_q) |-> !irq;
    endproperty
    a_ov_irq_off: assert property (p_ov_irq_off) else $error("ov irq while disabled"); // RULE2

    property p_filt_hold;
        @(posedge clk) disable iff (rst)
        (!sampleTick && !ocClear) |=> $stable(accepted_q[0]);
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter moved off tick"); // RULE12
endmodule

/* tb/analog_model.sv */
// Behavioural detectors and charge pump facing the monitor.
`timescale 1ns/1ps
module analog_model
    import ldo_monitor_pkg::*;
(
    // Levels chosen by the bench
    input wire logic pumpLevel,
    input wire logic ocLevel,
    input wire logic ovLevel,
    // Control from the monitor
    input wire logic detectEnable,
    // Detector outputs
    output detect_t detect
);
    assign detect.pumpOk = pumpLevel;
    assign detect.overCurrent = ocLevel;
    assign detect.overVoltage = ovLevel & detectEnable;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the regulator monitor register bank.
`timescale 1ns/1ps
module testbench
    import ldo_monitor_pkg::*;
;
    localparam int Div = 4;
    logic clk = 0, rst = 1, pump = 0, oc = 0, ov = 0, irq, ovEn;
    bus_req_t busReq = '0;
    detect_t detect;
    logic [15:0] rdata, r;
    logic [8:0] cTrim, vTrim;
    int failures = 0, comparisons = 0, seed = 73300;
    int ctrl = 0, ocL = 0, ovL = 0, overcurrent_sticky_flag = 0, ovF = 0;

    ldo_monitor_register_bank #(.DivideBy(Div)) DUT (.clk(clk), .rst(rst), .busReq(busReq),
        .rdata(rdata), .detect(detect), .overvoltageDetectEnable(ovEn),
        .currentTrimValue(cTrim), .voltageTrimValue(vTrim), .irq(irq));
    analog_model PM (.pumpLevel(pump), .ocLevel(oc), .ovLevel(ov), .detectEnable(ovEn),
        .detect(detect));

    initial forever #12.5 clk = ~clk;

    function automatic logic [15:0] st();
        return 16'({pump, 11'h000, ocL[0], ovL[0], overcurrent_sticky_flag[0], ovF[0]});
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask
    task close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        close_out;
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int a = 0; a <= 14; a += 2) rd(a[3:0], 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = 16'($random(seed));
            wr(CurTrimOffset, r);
            wr(VolTrimOffset, ~r);
            rd(CurTrimOffset, r & 16'h01ff);
            rd(VolTrimOffset, ~r & 16'h01ff);
            chk({7'h00, cTrim ^ vTrim}, 16'h01ff);
        end
        wr(CtrlOffset, r);
        ctrl = r;
        rd(CtrlOffset, 16'(ctrl));
        chk(16'(ovEn), 16'(ctrl & 1));
        wr(CtrlOffset, 16'h0000);
        $display("test trim done");
        pump <= 1;
        wr(StatusOffset, 16'hfffc);
        rd(StatusOffset, st());
        oc <= 1;
        cyc(3 * Div);
        ocL = 1;
        overcurrent_sticky_flag = 1;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0000);
        wr(CtrlOffset, 16'h0004);
        cyc(1);
        chk(16'(irq), 16'h0001);
        oc <= 0;
        cyc(3 * Div);
        ocL = 0;
        rd(StatusOffset, st());
        wr(StatusOffset, 16'h0002);
        overcurrent_sticky_flag = 0;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0000);
        $display("test overcurrent done");
        ov <= 1;
        wr(CtrlOffset, 16'h0000);
        cyc(3 * Div);
        rd(StatusOffset, st());
        wr(CtrlOffset, 16'h0003);
        cyc(3 * Div);
        ovL = 1;
        ovF = 1;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0001);
        chk(16'(ovEn), 16'h0001);
        ov <= 0;
        cyc(3 * Div);
        ovL = 0;
        wr(StatusOffset, 16'h0001);
        ovF = 0;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0000);
        $display("test overvoltage done");
        wr(OvFiltOffset, 16'h0002);
        rd(OvFiltOffset, 16'h0002);
        wr(OcFiltOffset, 16'h0003);
        rd(OcFiltOffset, 16'h0003);
        oc <= 1;
        cyc(Div);
        rd(StatusOffset, st());
        cyc(4 * Div);
        ocL = 1;
        overcurrent_sticky_flag = 1;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0000);
        wr(StatusOffset, 16'h0002);
        ocL = 0;
        rd(StatusOffset, st());
        wr(StatusOffset, 16'h0002);
        overcurrent_sticky_flag = 0;
        rd(StatusOffset, st());
        oc <= 0;
        ov <= 1;
        rd(StatusOffset, st());
        cyc(3 * Div);
        ovL = 1;
        ovF = 1;
        rd(StatusOffset, st());
        chk(16'(irq), 16'h0001);
        $display("test filter done");
        close_out;
    end
endmodule
